// [serial_dac_defs.svh]
// Constants for the serial DAC input front end
`ifndef SERIAL_DAC_DEFS_SVH
`define SERIAL_DAC_DEFS_SVH

`define WORD_BITS      16
`define CODE_BITS      12
`define ZERO_OFS_BIN   12'h800
`define ZERO_TWOS      12'h000

`define PIN_SCLK       0
`define PIN_SIN        1
`define PIN_SYNC       2
`define PIN_LOAD       3
`define PIN_CLEAR      4
`define PIN_FMT        5
`define PIN_CHAIN      6
`define PIN_BIP        7
`define PIN_RST        8'h1C

`define REG_CTRL       8'h00
`define REG_STATUS     8'h04
`define REG_WORD       8'h08
`define CTRL_SCLR_BIT  0

`endif

// [serial_dac_pkg.sv]
// Types for the serial DAC input front end
package serial_dac_pkg;
  typedef enum logic [1:0] {
    FR_IDLE  = 2'b00,
    FR_SHIFT = 2'b01,
    FR_DONE  = 2'b11
  } frame_state_e;

  typedef logic [11:0] dac_code_t;

  typedef struct packed {
    logic      auto_upd;
    dac_code_t code;
  } buf_entry_s;
endpackage

// [serial_dac_if.sv]
// Serial DAC input shift register, update buffer, DAC latch and APB status
//
// The APB slave port and the address map were decided locally.
`timescale 1ns/1ps
`include "serial_dac_defs.svh"
module serial_dac_if #(
  parameter int BUF_DEPTH = 2
) (
  input  wire logic                      clk,
  input  wire logic                      rst,
  input  wire logic                      shift_clk,
  input  wire logic                      serial_in,
  input  wire logic                      frame_sync_n,
  input  wire logic                      latch_load_n,
  input  wire logic                      output_clear_n,
  input  wire logic                      format_select,
  input  wire logic                      chain_enable,
  input  wire logic                      range_bipolar,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [7:0]                paddr,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  output logic                           serial_out,
  output logic                           serial_out_oe,
  output serial_dac_pkg::dac_code_t      dac_code
);
  import serial_dac_pkg::*;

  localparam int NP = 8;
  localparam int PW = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;
  localparam int CW = PW + 1;

  function automatic logic [PW-1:0] inc_ptr(input logic [PW-1:0] p);
    inc_ptr = (p == PW'(BUF_DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  function automatic dac_code_t zero_code(input logic bip, input logic twos);
    zero_code = (bip && !twos) ? `ZERO_OFS_BIN : `ZERO_TWOS;
  endfunction

  logic [NP-1:0]  pins;
  logic [NP-1:0]  s1_ff;
  logic [NP-1:0]  s2_ff;
  logic           sclk_d_ff;
  logic           sync_d_ff;
  logic           ld_d_ff;
  frame_state_e   state_ff;
  logic [4:0]     bit_cnt_ff;
  logic [4:0]     cnt_b;
  logic [15:0]    sr_ff;
  logic [15:0]    nxt_sr;
  logic           auto_ff;
  buf_entry_s     buf_mem [BUF_DEPTH];
  buf_entry_s     head;
  logic [PW-1:0]  wr_ptr_ff;
  logic [PW-1:0]  rd_ptr_ff;
  logic [CW-1:0]  buf_cnt_ff;
  dac_code_t      dac_code_ff;
  dac_code_t      zcode;
  logic           serial_out_ff;
  logic           serial_out_oe_ff;
  logic           soft_clear_ff;
  logic [31:0]    prdata_ff;
  logic           pready_ff;
  logic           pslverr_ff;
  logic           sclk_s;
  logic           sin_s;
  logic           sync_s;
  logic           ld_s;
  logic           chain_s;
  logic           sclk_fall;
  logic           sync_fall;
  logic           ld_fall;
  logic           counting;
  logic           buf_in_ready;
  logic           shift_en;
  logic           push;
  logic           pop;
  logic           out_valid;
  logic           clear_act;
  logic           setup;
  logic           mapped;
  logic [31:0]    rd_mux;

  assign pins = {range_bipolar, chain_enable, format_select, output_clear_n,
                 latch_load_n, frame_sync_n, serial_in, shift_clk};

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_ff <= `PIN_RST;
      s2_ff <= `PIN_RST;
    end else begin
      s1_ff <= pins;
      s2_ff <= s1_ff;
    end
  end

  assign sclk_s  = s2_ff[`PIN_SCLK];
  assign sin_s   = s2_ff[`PIN_SIN];
  assign sync_s  = s2_ff[`PIN_SYNC];
  assign ld_s    = s2_ff[`PIN_LOAD];
  assign chain_s = s2_ff[`PIN_CHAIN];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sclk_d_ff <= 1'b0;
      sync_d_ff <= 1'b1;
      ld_d_ff   <= 1'b1;
    end else begin
      sclk_d_ff <= sclk_s;
      sync_d_ff <= sync_s;
      ld_d_ff   <= ld_s;
    end
  end

  assign sclk_fall = sclk_d_ff & ~sclk_s;
  assign sync_fall = sync_d_ff & ~sync_s;
  assign ld_fall   = ld_d_ff & ~ld_s;

  // Data and clock share the sync delay, so they stay aligned
  assign counting     = sync_fall | (state_ff == FR_SHIFT);
  assign buf_in_ready = (buf_cnt_ff != CW'(BUF_DEPTH));
  assign shift_en     = sclk_fall & ~sync_s & (chain_s | (counting & buf_in_ready));
  assign cnt_b        = sync_fall ? 5'h0 : bit_cnt_ff;
  assign nxt_sr       = {sr_ff[14:0], sin_s};
  assign push         = shift_en & counting & buf_in_ready & (cnt_b == 5'(`WORD_BITS - 1));

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_ff <= FR_IDLE;
    end else begin
      case (state_ff)
        FR_IDLE:  state_ff <= sync_fall ? FR_SHIFT : FR_IDLE;
        FR_SHIFT: state_ff <= sync_s ? FR_IDLE : (push ? FR_DONE : FR_SHIFT);
        FR_DONE:  state_ff <= sync_s ? FR_IDLE : FR_DONE;
        default:  state_ff <= FR_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bit_cnt_ff <= 5'h0;
    end else if (shift_en && counting) begin
      bit_cnt_ff <= cnt_b + 5'h1;
    end else if (sync_fall) begin
      bit_cnt_ff <= 5'h0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sr_ff <= 16'h0000;
    end else if (shift_en) begin
      sr_ff <= nxt_sr;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      auto_ff <= 1'b0;
    end else if (sync_fall) begin
      auto_ff <= ~ld_s;
    end
  end

  // Two-entry buffer; outside chain mode, held words stall new frames when full
  assign head      = buf_mem[rd_ptr_ff];
  assign out_valid = (buf_cnt_ff != '0);
  assign clear_act = ~s2_ff[`PIN_CLEAR] | soft_clear_ff;
  assign pop       = out_valid & ~clear_act & (head.auto_upd | ld_fall);

  always_ff @(posedge clk) begin
    if (push) begin
      buf_mem[wr_ptr_ff] <= '{auto_upd: sync_fall ? ~ld_s : auto_ff,
                              code: nxt_sr[`CODE_BITS-1:0]};
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr_ff  <= '0;
      rd_ptr_ff  <= '0;
      buf_cnt_ff <= '0;
    end else begin
      if (push) begin
        wr_ptr_ff <= inc_ptr(wr_ptr_ff);
      end
      if (pop) begin
        rd_ptr_ff <= inc_ptr(rd_ptr_ff);
      end
      buf_cnt_ff <= buf_cnt_ff + CW'(push) - CW'(pop);
    end
  end

  assign zcode = zero_code(s2_ff[`PIN_BIP], s2_ff[`PIN_FMT]);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dac_code_ff <= `ZERO_TWOS;
    end else if (clear_act) begin
      dac_code_ff <= zcode;
    end else if (pop) begin
      dac_code_ff <= head.code;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      serial_out_ff    <= 1'b0;
      serial_out_oe_ff <= 1'b0;
    end else begin
      serial_out_ff    <= chain_s & sr_ff[15];
      serial_out_oe_ff <= chain_s;
    end
  end

  // APB slave, one wait-free access phase
  assign setup  = psel & ~penable;
  assign mapped = (paddr == `REG_CTRL) | (paddr == `REG_STATUS) | (paddr == `REG_WORD);

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (paddr)
      `REG_CTRL:   rd_mux = 32'(soft_clear_ff);
      `REG_STATUS: rd_mux = 32'({buf_cnt_ff, s2_ff[`PIN_FMT], chain_s, s2_ff[`PIN_BIP],
                                 auto_ff, state_ff != FR_IDLE, dac_code_ff});
      `REG_WORD:   rd_mux = 32'(sr_ff);
      default:     rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
    end else begin
      pready_ff  <= setup;
      pslverr_ff <= setup & ~mapped;
      prdata_ff  <= setup ? rd_mux : 32'h0000_0000;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      soft_clear_ff <= 1'b0;
    end else if (psel && penable && pready_ff && pwrite && paddr == `REG_CTRL) begin
      soft_clear_ff <= pwdata[`CTRL_SCLR_BIT];
    end
  end

  assign prdata        = prdata_ff;
  assign pready        = pready_ff;
  assign pslverr       = pslverr_ff;
  assign serial_out    = serial_out_ff;
  assign serial_out_oe = serial_out_oe_ff;
  assign dac_code      = dac_code_ff;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_shift;
    shift_en |=> sr_ff[0] == $past(sin_s) && sr_ff[15:1] == $past(sr_ff[14:0]);
  endproperty
  a_shift: assert property (p_shift) else $error("serial bit not shifted");

  property p_len;
    push |=> bit_cnt_ff == 5'd16 && state_ff == FR_DONE;
  endproperty
  a_len: assert property (p_len) else $error("word length not sixteen");

  property p_start;
    sync_fall && !shift_en |=> bit_cnt_ff == 5'd0 && state_ff == FR_SHIFT;
  endproperty
  a_start: assert property (p_start) else $error("frame start did not restart count");

  property p_strobe;
    ld_fall && out_valid && !head.auto_upd && !clear_act |=> dac_code_ff == $past(head.code);
  endproperty
  a_strobe: assert property (p_strobe) else $error("strobe load missed");

  property p_auto;
    (push && !(sync_fall ? ld_s : ~auto_ff) && buf_cnt_ff == '0 && !clear_act) ##1 !clear_act
      |=> dac_code_ff == $past(nxt_sr[11:0], 2);
  endproperty
  a_auto: assert property (p_auto) else $error("auto update missed");

  property p_clear;
    clear_act |=> dac_code_ff == $past(zcode);
  endproperty
  a_clear: assert property (p_clear) else $error("clear code wrong");

  property p_offbin;
    !s2_ff[`PIN_CLEAR] && s2_ff[`PIN_BIP] && !s2_ff[`PIN_FMT] ##1 !s2_ff[`PIN_CLEAR] |-> dac_code_ff == 12'h800;
  endproperty
  a_offbin: assert property (p_offbin) else $error("offset binary zero code wrong");

  property p_chain;
    chain_s |=> serial_out_oe_ff && serial_out_ff == $past(sr_ff[15]);
  endproperty
  a_chain: assert property (p_chain) else $error("chain output wrong");

  property p_lock;
    !chain_s && state_ff == FR_DONE && sclk_fall && !sync_fall |=> $stable(sr_ff);
  endproperty
  a_lock: assert property (p_lock) else $error("shift after sixteen edges");

  property p_edge;
    sclk_fall |-> $past(shift_clk, 3) && !$past(shift_clk, 2);
  endproperty
  a_edge: assert property (p_edge) else $error("edge not from synced samples");

  property p_solo;
    !chain_s |=> !serial_out_oe_ff && !serial_out_ff;
  endproperty
  a_solo: assert property (p_solo) else $error("serial output active outside chain mode");

  property p_zero;
    clear_act && !(s2_ff[`PIN_BIP] && !s2_ff[`PIN_FMT]) |=> dac_code_ff == `ZERO_TWOS;
  endproperty
  a_zero: assert property (p_zero) else $error("zero code not all zeros");

  c_auto:   cover property (push && auto_ff ##2 !clear_act);
  c_strobe: cover property (pop && !head.auto_upd);
  c_full:   cover property (buf_cnt_ff == CW'(BUF_DEPTH));
  c_chain:  cover property (chain_s && push);
endmodule

// [serial_host.sv]
// Host serial port model driving the DAC link pins
`timescale 1ns/1ps
module serial_host (
  input  wire logic clk,
  output logic      shift_clk,
  output logic      serial_in,
  output logic      frame_sync_n,
  output logic      latch_load_n
);
  initial begin
    shift_clk = 1'b0;
    serial_in = 1'b0;
    frame_sync_n = 1'b1;
    latch_load_n = 1'b1;
  end

  // Half of the 400 ns shift period
  task automatic half();
    repeat (4) @(posedge clk);
  endtask

  // word MSB first, sync raised after
  task automatic send(input logic [15:0] w, input logic auto_mode, input int edges);
    latch_load_n <= ~auto_mode;
    half();
    frame_sync_n <= 1'b0;
    for (int i = 0; i < edges; i++) begin
      shift_clk <= 1'b1;
      serial_in <= w[15 - (i % 16)];
      half();
      shift_clk <= 1'b0;
      half();
    end
    frame_sync_n <= 1'b1;
    // Released data line shows no stale bit
    serial_in <= ~serial_in;
    half();
  endtask

  // strobe after transfer, high before next
  task automatic strobe();
    latch_load_n <= 1'b0;
    half();
    latch_load_n <= 1'b1;
    half();
  endtask
endmodule

// [testbench.sv]
// Self-checking bench for the serial DAC front end
`timescale 1ns/1ps
module testbench;
  import serial_dac_pkg::*;
  logic        clk;
  logic        rst            = 1'b1;
  logic        output_clear_n = 1'b1;
  logic        format_select  = 1'b0;
  logic        chain_enable   = 1'b0;
  logic        range_bipolar  = 1'b0;
  logic        psel           = 1'b0;
  logic        penable        = 1'b0;
  logic        pwrite         = 1'b0;
  logic [7:0]  paddr          = 8'h00;
  logic [31:0] pwdata         = 32'h0000_0000;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic        err;
  logic        pready;
  logic        pslverr;
  logic        serial_out;
  logic        serial_out_oe;
  logic        shift_clk;
  logic        serial_in;
  logic        frame_sync_n;
  logic        latch_load_n;
  dac_code_t   dac_code;
  logic [13:0] clear_tab [3] = '{{1'b0, 1'b0, 12'h000}, {1'b1, 1'b0, 12'h800}, {1'b1, 1'b1, 12'h000}};
  logic [15:0] chain_tab [2] = '{16'hC3A5, 16'h4000};
  int          failures    = 0;
  int          comparisons = 0;
  int          cycles      = 0;

  serial_host host (.clk(clk), .shift_clk(shift_clk), .serial_in(serial_in), .frame_sync_n(frame_sync_n),
                    .latch_load_n(latch_load_n));

  serial_dac_if #(.BUF_DEPTH(2)) uut (.clk(clk), .rst(rst), .shift_clk(shift_clk), .serial_in(serial_in),
    .frame_sync_n(frame_sync_n), .latch_load_n(latch_load_n), .output_clear_n(output_clear_n),
    .format_select(format_select), .chain_enable(chain_enable), .range_bipolar(range_bipolar), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .serial_out(serial_out), .serial_out_oe(serial_out_oe), .dac_code(dac_code));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Frames take about 140 cycles; ceiling is far above the full run
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      final_report();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Setup, then access until pready; data taken at that edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Idle edge so a following call never re-drives psel in this step
    @(posedge clk);
  endtask

  task automatic final_report();
    if (failures == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    wait_clk(8);
    rst <= 1'b0;
    wait_clk(1);
    check(dac_code, 12'h000);
    check(serial_out_oe, 1'b0);
    apb(1'b0, 8'h0C, 32'h0000_FFFF);
    check(err, 1'b1);
    check(rd, 32'h0000_0000);
    host.send(16'hFABC, 1'b1, 16);
    check(dac_code, 12'hABC);
    host.send(16'h0123, 1'b0, 16);
    check(dac_code, 12'hABC);
    host.strobe();
    check(dac_code, 12'h123);
    host.send(16'h8421, 1'b1, 20);
    check(dac_code, 12'h421);
    apb(1'b0, 8'h08, 32'h0);
    check(rd, 32'h0000_8421);
    host.send(16'hFFFF, 1'b1, 8);
    check(dac_code, 12'h421);
    host.send(16'h0FFF, 1'b1, 16);
    check(dac_code, 12'hFFF);
    // Third frame stalls while two words wait
    host.send(16'h0111, 1'b0, 16);
    host.send(16'h0222, 1'b0, 16);
    host.send(16'h0333, 1'b0, 16);
    apb(1'b0, 8'h04, 32'h0);
    check(rd[18:17], 2'd2);
    host.strobe();
    check(dac_code, 12'h111);
    host.strobe();
    check(dac_code, 12'h222);
    host.strobe();
    check(dac_code, 12'h222);
    for (int i = 0; i < 3; i++) begin
      range_bipolar <= clear_tab[i][13];
      format_select <= clear_tab[i][12];
      output_clear_n <= 1'b0;
      wait_clk(6);
      check(dac_code, clear_tab[i][11:0]);
      apb(1'b0, 8'h04, 32'h0);
      check({rd[14], rd[16], rd[11:0]}, clear_tab[i]);
      output_clear_n <= 1'b1;
      wait_clk(6);
    end
    range_bipolar <= 1'b0;
    format_select <= 1'b0;
    host.send(16'h0ABC, 1'b1, 16);
    check(dac_code, 12'hABC);
    apb(1'b1, 8'h00, 32'h0000_0001);
    apb(1'b0, 8'h00, 32'h0);
    check(rd, 32'h0000_0001);
    wait_clk(3);
    check(dac_code, 12'h000);
    apb(1'b1, 8'h00, 32'h0000_0000);
    chain_enable <= 1'b1;
    wait_clk(6);
    check(serial_out_oe, 1'b1);
    foreach (chain_tab[i]) begin
      host.send(chain_tab[i], 1'b1, 16);
      check(serial_out, chain_tab[i][15]);
      check(dac_code, chain_tab[i][11:0]);
    end
    chain_enable <= 1'b0;
    wait_clk(6);
    check({serial_out_oe, serial_out}, 2'b00);
    final_report();
  end
endmodule
